// [hdl/dac_digital_volume_path.sv]
/*
   Sample FIFO and the playback volume path: source select, enable gate,
   log volume with mute and soft ramp, linear interpolation to an oversampled
   word stream. Assumes sample sources and sample_tick run on clk, and that
   sample_tick pulses are at least 2**OS_SHIFT + 2 cycles apart.
*/
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 24,
   parameter int DEPTH = 16
) (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     wr_valid,
   output logic                          wr_ready,
   input  wire logic [WIDTH-1:0]         wr_data,
   output logic                          rd_valid,
   input  wire logic                     rd_ready,
   output logic [WIDTH-1:0]              rd_data,
   output logic [$clog2(DEPTH+1)-1:0]    level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0]          mem_q [DEPTH];
   logic [AW-1:0]             wp_q;
   logic [AW-1:0]             rp_q;
   logic [$clog2(DEPTH+1)-1:0] cnt_q;
   logic                      push;
   logic                      pop;

   assign wr_ready = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign rd_valid = (cnt_q != '0);
   assign rd_data  = mem_q[rp_q];
   assign level    = cnt_q;
   assign push     = wr_valid & wr_ready;
   assign pop      = rd_valid & rd_ready;

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem_q[wp_q] <= wr_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end
      else
      begin
         wp_q  <= push ? wp_q + 1'b1 : wp_q;
         rp_q  <= pop ? rp_q + 1'b1 : rp_q;
         cnt_q <= cnt_q + {{($clog2(DEPTH+1)-1){1'b0}}, push} - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
      end
   end
endmodule : sample_fifo

module dac_digital_volume_path #(
   parameter int SW     = dac_vol_pkg::SAMPLE_W,
   parameter int DEPTH  = dac_vol_pkg::FIFO_DEPTH,
   parameter int OSHIFT = dac_vol_pkg::OS_SHIFT
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          reg_wr,
   input  wire logic [6:0]    reg_addr,
   input  wire logic [15:0]   reg_wdata,
   output logic [15:0]        reg_rdata_q,
   input  wire logic          dsp_route,
   input  wire logic          aif_valid,
   input  wire logic [SW-1:0] aif_data,
   output logic               aif_ready_q,
   input  wire logic          dsp_valid,
   input  wire logic [SW-1:0] dsp_data,
   output logic               dsp_ready_q,
   input  wire logic          sample_tick,
   output logic [SW-1:0]      os_data_q,
   output logic               os_valid_q,
   output logic [7:0]         gain_code_q
);
   localparam int LW = $clog2(DEPTH+1);
   localparam int PW = SW + 16;

   logic          enable_q;
   logic          ramp_q;
   logic          mute_q;
   logic [7:0]    vol_q;
   logic          half_q;
   logic [7:0]    target;
   logic [SW-1:0] in_mux;
   logic          in_valid;
   logic          fifo_ready;
   logic          fifo_valid;
   logic [SW-1:0] fifo_data;
   logic [LW-1:0] fifo_level;
   logic          take;
   logic [8:0]    rel;
   logic signed [PW-1:0] prod;
   logic signed [PW-1:0] shifted;
   logic [4:0]    shamt;
   logic signed [SW-1:0] scaled;
   logic signed [SW-1:0] tgt_q;
   logic signed [SW-1:0] step_q;
   logic [OSHIFT:0] cnt_q;
   logic [OSHIFT:0] run_q;

   // Register writes
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         enable_q <= dac_vol_pkg::ENABLE_RESET;
         ramp_q   <= dac_vol_pkg::RAMP_RESET;
         mute_q   <= dac_vol_pkg::MUTE_RESET;
         vol_q    <= dac_vol_pkg::VOL_RESET;
      end
      else if (reg_wr)
      begin
         if (reg_addr == dac_vol_pkg::ADDR_POWER_CONTROL_TWO)
            enable_q <= reg_wdata[dac_vol_pkg::ENABLE_BIT];
         if (reg_addr == dac_vol_pkg::ADDR_PLAYBACK_CONTROL_TWO)
            ramp_q <= reg_wdata[dac_vol_pkg::RAMP_BIT];
         if (reg_addr == dac_vol_pkg::ADDR_PLAYBACK_VOLUME)
         begin
            mute_q <= reg_wdata[dac_vol_pkg::MUTE_BIT];
            vol_q  <= reg_wdata[dac_vol_pkg::VOL_MSB:0];
         end
      end
   end

   // Register reads, unmapped and reserved bits read zero
   always_ff @(posedge clk)
   begin
      if (rst)
         reg_rdata_q <= 16'h0000;
      else
         case (reg_addr)
            dac_vol_pkg::ADDR_POWER_CONTROL_TWO:    reg_rdata_q <= {15'h0000, enable_q};
            dac_vol_pkg::ADDR_PLAYBACK_CONTROL_TWO: reg_rdata_q <= {11'h000, ramp_q, 4'h0};
            dac_vol_pkg::ADDR_PLAYBACK_VOLUME:      reg_rdata_q <= {7'h00, mute_q, vol_q};
            default:                                reg_rdata_q <= 16'h0000;
         endcase
   end

   // Source select into the FIFO
   assign in_mux   = dsp_route ? dsp_data : aif_data;
   assign in_valid = dsp_route ? dsp_valid : aif_valid;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aif_ready_q <= 1'b0;
         dsp_ready_q <= 1'b0;
      end
      else
      begin
         aif_ready_q <= ~dsp_route & (fifo_level < LW'(DEPTH - 1));
         dsp_ready_q <= dsp_route & (fifo_level < LW'(DEPTH - 1));
      end
   end

   sample_fifo #(.WIDTH(SW), .DEPTH(DEPTH)) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .wr_valid (in_valid & (dsp_route ? dsp_ready_q : aif_ready_q)),
      .wr_ready (fifo_ready),
      .wr_data  (in_mux),
      .rd_valid (fifo_valid),
      .rd_ready (sample_tick),
      .rd_data  (fifo_data),
      .level    (fifo_level)
   );

   // Gain target, ramp and sample boundary update
   assign target = (mute_q | ~enable_q) ? dac_vol_pkg::GAIN_SILENT : vol_q;
   assign take   = sample_tick & fifo_valid;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         gain_code_q <= dac_vol_pkg::GAIN_SILENT;
         half_q      <= 1'b0;
      end
      else if (sample_tick)
      begin
         half_q <= ~half_q;
         if (~enable_q)
            gain_code_q <= dac_vol_pkg::GAIN_SILENT;
         else if (~ramp_q)
            gain_code_q <= target;
         else if (half_q && gain_code_q < target)
            gain_code_q <= gain_code_q + 8'h01;
         else if (half_q && gain_code_q > target)
            gain_code_q <= gain_code_q - 8'h01;
      end
   end

   // Log gain: 16 codes per 6 dB octave, mantissa from table
   assign rel     = {1'b0, gain_code_q} - dac_vol_pkg::UNITY_CODE;
   assign prod    = $signed(fifo_data) * $signed({1'b0, dac_vol_pkg::MANT[rel[3:0]]});
   assign shamt   = 5'(dac_vol_pkg::MANT_FRAC) - 5'($signed(rel[8:4]));
   assign shifted = prod >>> shamt;

   always_comb
   begin
      if (gain_code_q == dac_vol_pkg::GAIN_SILENT)
         scaled = '0;
      else if (shifted > $signed({{(PW-SW+1){1'b0}}, {(SW-1){1'b1}}}))
         scaled = {1'b0, {(SW-1){1'b1}}};
      else if (shifted < -$signed({{(PW-SW+1){1'b0}}, {(SW-1){1'b1}}}) - 1)
         scaled = {1'b1, {(SW-1){1'b0}}};
      else
         scaled = shifted[SW-1:0];
   end

   // Linear interpolation, 2**OSHIFT output words per sample
   always_ff @(posedge clk)
   begin
      if (rst || !enable_q)
      begin
         os_data_q  <= '0;
         os_valid_q <= 1'b0;
         tgt_q      <= '0;
         step_q     <= '0;
         cnt_q      <= '0;
      end
      else if (take)
      begin
         tgt_q      <= scaled;
         step_q     <= SW'(($signed({scaled[SW-1], scaled}) - $signed({os_data_q[SW-1], os_data_q})) >>> OSHIFT);
         cnt_q      <= (OSHIFT+1)'(1 << OSHIFT);
         os_valid_q <= 1'b0;
      end
      else if (cnt_q != '0)
      begin
         os_data_q  <= (cnt_q == 1) ? tgt_q : os_data_q + step_q;
         os_valid_q <= 1'b1;
         cnt_q      <= cnt_q - 1'b1;
      end
      else
         os_valid_q <= 1'b0;
   end

   // Length of the current output burst, for the burst check
   always_ff @(posedge clk)
   begin
      if (rst || !os_valid_q)
         run_q <= '0;
      else
         run_q <= run_q + 1'b1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_burst_end;
      os_valid_q ##1 !os_valid_q;
   endsequence

   property p_disabled_silent;
      !enable_q |=> os_data_q == '0 && !os_valid_q;
   endproperty
   a_disabled_silent: assert property (p_disabled_silent) else $error("output not silent while disabled");

   property p_route;
      dsp_route |=> !aif_ready_q;
   endproperty
   a_route: assert property (p_route) else $error("audio interface ready while DSP routed");

   property p_no_drop;
      (dsp_route ? (dsp_valid && dsp_ready_q) : (aif_valid && aif_ready_q)) |-> fifo_ready;
   endproperty
   a_no_drop: assert property (p_no_drop) else $error("offered sample taken while FIFO full");

   property p_interp_len;
      s_burst_end ##0 enable_q |-> run_q == (OSHIFT+1)'(1 << OSHIFT);
   endproperty
   a_interp_len: assert property (p_interp_len) else $error("interpolation burst length wrong");

   property p_zero_code;
      enable_q && take && gain_code_q == 8'h00 |=> tgt_q == '0;
   endproperty
   a_zero_code: assert property (p_zero_code) else $error("code zero not silent");

   property p_reset_vals;
      rst |=> vol_q == dac_vol_pkg::VOL_RESET && mute_q && ramp_q && !enable_q;
   endproperty
   a_reset_vals: assert property (disable iff (1'b0) p_reset_vals) else $error("bad reset values");

   property p_mute;
      mute_q && enable_q && !ramp_q && sample_tick |=> gain_code_q == 8'h00;
   endproperty
   a_mute: assert property (p_mute) else $error("mute did not silence");

   property p_ramp_step;
      enable_q && ramp_q && sample_tick && half_q && gain_code_q != target
         |=> (gain_code_q == $past(gain_code_q) + 8'h01) || (gain_code_q == $past(gain_code_q) - 8'h01);
   endproperty
   a_ramp_step: assert property (p_ramp_step) else $error("ramp step not one code");

   property p_ramp_rate;
      enable_q && ramp_q && sample_tick && !half_q |=> $stable(gain_code_q);
   endproperty
   a_ramp_rate: assert property (p_ramp_rate) else $error("ramp faster than half rate");

   property p_direct;
      enable_q && !ramp_q && sample_tick |=> gain_code_q == $past(target);
   endproperty
   a_direct: assert property (p_direct) else $error("setting not applied directly");

   property p_hold_between;
      !sample_tick |=> $stable(gain_code_q) or $past(rst);
   endproperty
   a_hold_between: assert property (p_hold_between) else $error("gain moved off a sample boundary");
endmodule : dac_digital_volume_path

// [shared/dac_vol_pkg.sv]
/*
   Constants for the playback volume path: register offsets, field positions,
   reset values, gain codes and the log gain mantissa table.
   Assumes a 50 MHz system clock and a sample tick at the audio rate.
*/
// Contract
// - Path stays silent and idle while converter_enable (bit 0, reset 0) is clear; the FIFO still accepts samples and pops them unused at each sample_tick.
// - Samples come from the audio interface, or via the DSP core when routed.
// - Scaled samples are interpolated at 24-bit precision into an oversampled stream.
// - Code X in 1..255 gives 0.375 dB times (X-192); code zero silences.
// - Volume field is bits 7:0, resets to C0h (0 dB), spans -71.625..+23.625 dB.
// - Mute bit 8 of the volume register resets to 1 and silences when set.
// - With ramp bit 4 set (reset 1), mute, unmute and volume changes ramp gradually.
// - A ramp advances the applied gain at half the sample rate.
package dac_vol_pkg;
   localparam logic [6:0]  ADDR_POWER_CONTROL_TWO    = 7'h03;
   localparam logic [6:0]  ADDR_PLAYBACK_CONTROL_TWO = 7'h16;
   localparam logic [6:0]  ADDR_PLAYBACK_VOLUME      = 7'h17;
   localparam int          ENABLE_BIT                = 0;
   localparam int          RAMP_BIT                  = 4;
   localparam int          MUTE_BIT                  = 8;
   localparam int          VOL_MSB                   = 7;
   localparam logic        ENABLE_RESET              = 1'b0;
   localparam logic        RAMP_RESET                = 1'b1;
   localparam logic        MUTE_RESET                = 1'b1;
   localparam logic [7:0]  VOL_RESET                 = 8'hC0;
   localparam logic [7:0]  GAIN_SILENT               = 8'h00;
   localparam logic [8:0]  UNITY_CODE                = 9'h0C0;
   localparam int          SAMPLE_W                  = 24;
   localparam int          MANT_FRAC                 = 14;
   localparam int          FIFO_DEPTH                = 16;
   localparam int          OS_SHIFT                  = 6;
   localparam logic [15:0] MANT [16] = '{16'h4000, 16'h42D3, 16'h45C6, 16'h48D9,
                                         16'h4C10, 16'h4F6B, 16'h52EC, 16'h5695,
                                         16'h5A67, 16'h5E64, 16'h628E, 16'h66E7,
                                         16'h6B71, 16'h702F, 16'h7522, 16'h7A4D};
endpackage : dac_vol_pkg

// [verif/sample_source.sv]
/*
   Sample source model for one stream of the volume path.
   Assumes a registered ready on clk; signals change 1 ns after an edge.
*/
`timescale 1ns/1ps
module sample_source #(
   parameter int SW = 24
) (
   input  wire logic          clk,
   input  wire logic          stall_en,
   input  wire logic          ready,
   output logic               valid,
   output logic [SW-1:0]      data
);
   logic [SW-1:0] send_q [$];
   logic          taken;
   initial valid = 1'b0;
   initial data = '0;
   always @(posedge clk)
   begin
      taken = valid && ready;
      #1;
      if (taken)
         void'(send_q.pop_front());
      // Offer held until taken; idle data toggles
      if (!valid || taken)
      begin
         if (send_q.size() > 0 && !(stall_en && $urandom_range(0, 1) == 0))
         begin
            valid = 1'b1;
            data  = send_q[0];
         end
         else
         begin
            valid = 1'b0;
            data  = ~data;
         end
      end
   end
endmodule : sample_source

// [verif/testbench.sv]
/*
   Self-checking bench for the playback volume path.
   Assumes OSHIFT of 2, so ticks 13 cycles apart are legal.
*/
`timescale 1ns/1ps
module testbench;
   localparam int SW = 24;
   logic          clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, dsp_route = 1'b0;
   logic          sample_tick = 1'b0, stall_en = 1'b1, vprev = 1'b0;
   logic          aif_valid, aif_ready_q, dsp_valid, dsp_ready_q, os_valid_q;
   logic          cur_mute = 1'b1, cur_en = 1'b0;
   logic [6:0]    reg_addr = 7'h00;
   logic [15:0]   reg_wdata = 16'h0000, reg_rdata_q;
   logic [SW-1:0] aif_data, dsp_data, os_data_q, last_q;
   logic [7:0]    gain_code_q, cur_vol = 8'hC0, app_code = 8'h00;
   logic [SW-1:0] smp_q [$], exp_q [$];
   int            fail_count = 0, num_checks = 0;
   always #10 clk = ~clk;
   dac_digital_volume_path #(.OSHIFT(2)) DUT (
      .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .dsp_route(dsp_route),
      .aif_valid(aif_valid), .aif_data(aif_data), .aif_ready_q(aif_ready_q),
      .dsp_valid(dsp_valid), .dsp_data(dsp_data), .dsp_ready_q(dsp_ready_q),
      .sample_tick(sample_tick), .os_data_q(os_data_q), .os_valid_q(os_valid_q),
      .gain_code_q(gain_code_q));
   sample_source #(.SW(SW)) aif_src (.clk(clk), .stall_en(stall_en), .ready(aif_ready_q),
      .valid(aif_valid), .data(aif_data));
   sample_source #(.SW(SW)) dsp_src (.clk(clk), .stall_en(stall_en), .ready(dsp_ready_q),
      .valid(dsp_valid), .data(dsp_data));
   task check(input logic [SW-1:0] seen, input logic [SW-1:0] exp, input string what);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish
   task wr(input logic [6:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge clk);
      #1 reg_wr = 1'b0;
   endtask : wr
   task rd(input logic [6:0] a, input logic [15:0] exp);
      @(posedge clk);
      #1 reg_addr = a;
      repeat (2) @(posedge clk);
      #1 check(reg_rdata_q, exp, "reg_rdata");
   endtask : rd
   task setvol(input logic [7:0] v, input logic m);
      wr(7'h17, {7'h00, m, v});
      cur_vol = v;
      cur_mute = m;
   endtask : setvol
   task send(input logic dsp);
      logic [19:0] r;
      r = 20'($urandom);
      if (dsp)
         dsp_src.send_q.push_back({{4{r[19]}}, r[19:2], 2'b00});
      else
         aif_src.send_q.push_back({{4{r[19]}}, r[19:2], 2'b00});
      smp_q.push_back({{4{r[19]}}, r[19:2], 2'b00});
      for (int i = 0; i < 100 && aif_src.send_q.size() + dsp_src.send_q.size() > 0; i++)
         @(posedge clk);
   endtask : send
   // Notes the expected last word, then pulses the tick
   // A sample is scaled by the gain applied at the previous tick
   task tick;
      logic [SW-1:0] s;
      if (smp_q.size() > 0)
      begin
         s = smp_q.pop_front();
         if (app_code == 8'h00)
            s = '0;
         else if (app_code == 8'hD0)
            s = s <<< 1;
         else if (app_code == 8'hB0)
            s = $signed(s) >>> 1;
         if (cur_en)
            exp_q.push_back(s);
      end
      app_code = (cur_en && !cur_mute) ? cur_vol : 8'h00;
      @(posedge clk);
      #1 sample_tick = 1'b1;
      @(posedge clk);
      #1 sample_tick = 1'b0;
      repeat (11) @(posedge clk);
      #1;
   endtask : tick
   always @(posedge clk)
   begin
      if (vprev && !os_valid_q)
      begin
         if (exp_q.size() == 0)
            check(1, 0, "unexpected_output");
         else
            check(last_q, exp_q.pop_front(), "os_data");
      end
      vprev <= os_valid_q;
      last_q <= os_data_q;
   end
   initial
   begin
      #400000;
      fail_count++;
      tally_and_finish();
   end
   initial
   begin
      void'($urandom(32'h2551df56));
      repeat (8) @(posedge clk);
      #1 rst = 1'b0;
      rd(7'h03, 16'h0000);
      rd(7'h16, 16'h0010);
      rd(7'h17, 16'h01C0);
      wr(7'h05, 16'hFFFF);
      rd(7'h05, 16'h0000);
      send(1'b0);
      tick();
      check(gain_code_q, 8'h00, "gain_disabled");
      wr(7'h16, 16'h0000);
      wr(7'h03, 16'h0001);
      cur_en = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         dsp_route = i[0];
         setvol(i == 0 ? 8'hC0 : i == 1 ? 8'hD0 : i == 2 ? 8'hB0 : 8'h00, 1'b0);
         send(i[0]);
         tick();
         check(gain_code_q, cur_vol, "gain_direct");
      end
      dsp_route = 1'b0;
      setvol(8'hC0, 1'b1);
      send(1'b0);
      tick();
      check(gain_code_q, 8'h00, "gain_muted");
      setvol(8'hC0, 1'b0);
      stall_en = 1'b0;
      for (int i = 0; i < 20; i++)
         aif_src.send_q.push_back(SW'(i * 4 + 24'h100000));
      for (int i = 0; i < 20; i++)
         smp_q.push_back(SW'(i * 4 + 24'h100000));
      repeat (30) @(posedge clk);
      #1;
      check(aif_ready_q, 1'b0, "fifo_full_ready");
      repeat (20) tick();
      check(aif_ready_q, 1'b1, "fifo_empty_ready");
      stall_en = 1'b1;
      wr(7'h16, 16'h0010);
      setvol(8'hC4, 1'b0);
      repeat (2) tick();
      check(gain_code_q, 8'hC1, "ramp_rate");
      repeat (6) tick();
      check(gain_code_q, 8'hC4, "ramp_reach");
      repeat (2) tick();
      check(gain_code_q, 8'hC4, "ramp_stop");
      setvol(8'hC4, 1'b1);
      repeat (2) tick();
      check(gain_code_q, 8'hC3, "ramp_mute");
      wr(7'h03, 16'h0000);
      cur_en = 1'b0;
      tick();
      check(gain_code_q, 8'h00, "gain_off");
      check(SW'(exp_q.size()), '0, "pending_outputs");
      tally_and_finish();
   end
endmodule : testbench
